/* File: inc/bae_pkg.sv */
// Contract
// R1 - Read timeout after 100 us, never prefetch
// R2 - Read substitute sets flag, withholds peripheral data
// R3 - Corrected read data sets bit 8
// R4 - Error confirmation sets command error, not prefetch
// R5 - Command not done in 100 us sets timeout
// R6 - Data path parity error sets path flag
// R7 - Unvalidated, undisabled map entry sets invalid flag
// R8 - Map upper half parity error sets flag
// R9 - Seven DMA flags lock; entry register follows
// R10 - DMA field flag raises enabled interrupt
// R11 - Error while locked sets lost flag, no interrupt
// R12 - No mastership in 50 us sets select timeout
// R13 - No slave response in 12.8 us sets flag
// R14 - Two transfer timeouts lock, cleared by one
// R15 - Transfer timeout raises enabled interrupt
// R16 - Timeouts freeze failed peripheral address
// R17 - Bit 31 spare, cleared by init or dead
// R18 - Bit 30 ignores peripheral interrupts
// R19 - Bit 29 zeroes map parity to checkers
// R20 - Bit 28 zeroes data path parity
// R21 - Bit 27 shows sequencer idle; reinit forced
// R22 - Failed entry read only; write gives error
// R23 - Entry number in bits 8..0
// R24 - Write one clears DMA and lost flags
package bae_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] DIAG_OFS = 8'h0C;
   localparam logic [7:0] ENTRY_OFS = 8'h10;
   // Status bit positions
   localparam int B_RD_TMO = 10;
   localparam int B_RD_SUB = 9;
   localparam int B_CORR = 8;
   localparam int B_CMD_ERR = 7;
   localparam int B_CMD_TMO = 6;
   localparam int B_PATH_PAR = 5;
   localparam int B_BAD_MAP = 4;
   localparam int B_MAP_PAR = 3;
   localparam int B_LOST = 2;
   localparam int B_STO = 1;
   localparam int B_SYNC = 0;
   localparam int STATUS_W = 11;
   localparam logic [10:0] DMA_LOCK_MASK = 11'h6F8;
   localparam logic [10:0] PF_LOCK_MASK = 11'h003;
   localparam logic [10:0] STATUS_RST = 11'h000;
   // Diagnostic register layout
   localparam int DIAG_LSB = 28;
   localparam int B_SPARE = 3;
   localparam int B_INTR_IGN = 2;
   localparam int B_MAP_DEF = 1;
   localparam int B_PATH_DEF = 0;
   localparam int B_SEQ_IDLE = 27;
   localparam logic [3:0] DIAG_RST = 4'h0;
   localparam int CFG_W = 24;
   localparam int ENTRY_W = 9;
   localparam int FAIL_ADDR_W = 16;
   localparam int GROUP_LSB = 4;
   // Timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int T_READ_NS = 100000;
   localparam int T_CMD_NS = 100000;
   localparam int T_SEL_NS = 50000;
   localparam int T_SYNC_NS = 12800;
   localparam int READ_TMO_CYC = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CMD_TMO_CYC = (T_CMD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEL_TMO_CYC = (T_SEL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_TMO_CYC = (T_SYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Backplane operation in progress
   typedef enum logic [2:0] {
      OP_NONE, OP_DIRECT, OP_BREAD, OP_BWRITE, OP_PURGE, OP_PREFETCH
   } op_e;
endpackage : bae_pkg

/* File: inc/xfer_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Start, stop and expiry of one timeout watch
interface xfer_timer_if;
   logic start;
   logic stop;
   logic expire;
   modport ctl (output start, output stop, input expire);
   modport tmr (input start, input stop, output expire);
endinterface : xfer_timer_if
`default_nettype wire

/* File: rtl/xfer_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module xfer_timer #(
   parameter int CYCLES = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Control
   xfer_timer_if.tmr tif
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   typedef struct packed {
      logic run;
      logic [W-1:0] cnt;
      logic exp;
   } tstate_s;
   tstate_s s_r;
   tstate_s s_nxt;

   // Start restarts the count, so a retry never inherits old time
   always_comb begin
      s_nxt = s_r;
      s_nxt.exp = 1'b0;
      if (tif.start) begin
         s_nxt.run = 1'b1;
         s_nxt.cnt = '0;
      end else if (tif.stop) begin
         s_nxt.run = 1'b0;
      end else if (s_r.run) begin
         if (s_r.cnt == LAST) begin
            s_nxt.run = 1'b0;
            s_nxt.exp = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tif.expire = s_r.exp;
endmodule : xfer_timer
`default_nettype wire

/* File: rtl/odd_parity_check.sv */
`timescale 1ns/10ps
`default_nettype none
module odd_parity_check #(
   parameter int BYTES = 2
) (
   // Checked word
   input wire logic [8*BYTES-1:0] i_data,
   input wire logic [BYTES-1:0] i_par,
   input wire logic i_defeat,
   // Result
   output logic o_err
);
   logic [BYTES-1:0] byte_bad;

   // Each byte plus its parity bit must hold an odd count of ones
   genvar g;
   for (g = 0; g < BYTES; g++) begin : g_byte
      assign byte_bad[g] = ~^{i_data[8*g +: 8], i_par[g] & ~i_defeat}; // [R19] [R20]
   end

   assign o_err = |byte_bad;
endmodule : odd_parity_check
`default_nettype wire

/* File: rtl/bus_adapter_error_status.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_adapter_error_status #(
   parameter int READ_TMO = bae_pkg::READ_TMO_CYC,
   parameter int CMD_TMO = bae_pkg::CMD_TMO_CYC,
   parameter int SEL_TMO = bae_pkg::SEL_TMO_CYC
) (
   // Clock, reset and initialisation sources
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_adapter_init,
   input wire logic i_backplane_dead,
   input wire logic i_dc_low,
   // Register port from the backplane processor
   input wire logic i_reg_sel,
   input wire logic i_reg_write,
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_reg_err,
   // Control register bits held elsewhere
   input wire logic i_dma_error_irq_enable,
   input wire logic i_periph_xfer_irq_enable,
   input wire logic [4:0] i_map_disable_field,
   input wire logic [bae_pkg::CFG_W-1:0] i_config_low,
   // DMA side events
   input wire bae_pkg::op_e i_op,
   input wire logic i_dma_read,
   input wire logic i_periph_timed_out,
   input wire logic i_mem_read_sent,
   input wire logic i_mem_data_ret,
   input wire logic i_sub_resp,
   input wire logic i_corr_resp,
   input wire logic i_cmd_sent,
   input wire logic i_cmd_done,
   input wire logic i_cmd_err_conf,
   // Data path and map checks
   input wire logic i_dp_check,
   input wire logic [31:0] i_dp_data,
   input wire logic [3:0] i_dp_par,
   input wire logic i_map_lookup,
   input wire logic [bae_pkg::ENTRY_W-1:0] i_map_entry,
   input wire logic i_map_valid,
   input wire logic [15:0] i_map_hi,
   input wire logic [1:0] i_map_hi_par,
   // Software initiated peripheral transfers
   input wire logic i_xfer_start,
   input wire logic [17:0] i_xfer_addr,
   input wire logic i_sel_request,
   input wire logic i_bus_granted,
   input wire logic i_data_cycle,
   input wire logic i_slave_resp,
   // Sequencer
   input wire logic i_seq_idle,
   // Outputs to the adapter
   output logic o_periph_data_en,
   output logic o_dma_err_irq,
   output logic o_periph_irq,
   output logic o_interrupt_ignore,
   output logic o_seq_reinit,
   output logic [bae_pkg::FAIL_ADDR_W-1:0] o_failed_periph_address
);
   import bae_pkg::*;

   typedef struct packed {
      logic [STATUS_W-1:0] status;
      logic [3:0] diag;
      logic [ENTRY_W-1:0] entry;
      logic [FAIL_ADDR_W-1:0] fail_addr;
      logic [31:0] rdata;
      logic ack;
      logic err;
   } state_s;
   state_s s_r;
   state_s s_nxt;

   localparam int TMO_CYC [4] = '{READ_TMO, CMD_TMO, SEL_TMO, SYNC_TMO_CYC};
   localparam int T_READ = 0;
   localparam int T_CMD = 1;
   localparam int T_SEL = 2;
   localparam int T_SYNC = 3;

   xfer_timer_if tmr_if [4] ();
   logic [STATUS_W-1:0] ev;
   logic [STATUS_W-1:0] clr;
   logic dp_perr;
   logic map_perr;
   logic map_dis;
   logic dma_locked;
   logic pf_locked;
   logic reinit;
   logic wr_status;
   logic mapped_op;
   logic [3:0] expired;

   // One watch per timed wait; each holds its own count
   genvar g;
   for (g = 0; g < 4; g++) begin : g_tmr
      xfer_timer #(.CYCLES(TMO_CYC[g])) u_tmr (
         .i_clk(i_clk),
         .i_resetn(i_resetn),
         .tif(tmr_if[g])
      );
   end

   // Timer starts and stops
   assign tmr_if[T_READ].start = i_mem_read_sent;
   assign tmr_if[T_READ].stop = i_mem_data_ret | i_sub_resp;
   assign tmr_if[T_CMD].start = i_cmd_sent;
   assign tmr_if[T_CMD].stop = i_cmd_done | i_cmd_err_conf;
   assign tmr_if[T_SEL].start = i_sel_request;
   assign tmr_if[T_SEL].stop = i_bus_granted;
   assign tmr_if[T_SYNC].start = i_data_cycle;
   assign tmr_if[T_SYNC].stop = i_slave_resp;
   assign expired = {tmr_if[T_SYNC].expire, tmr_if[T_SEL].expire,
                     tmr_if[T_CMD].expire, tmr_if[T_READ].expire};

   // Parity checkers; defeat bits withhold stored parity
   odd_parity_check #(.BYTES(2)) u_map_par (
      .i_data(i_map_hi),
      .i_par(i_map_hi_par),
      .i_defeat(s_r.diag[B_MAP_DEF]),
      .o_err(map_perr)
   );
   odd_parity_check #(.BYTES(4)) u_dp_par (
      .i_data(i_dp_data),
      .i_par(i_dp_par),
      .i_defeat(s_r.diag[B_PATH_DEF]),
      .o_err(dp_perr)
   );

   // Disabled groups of sixteen entries raise no map errors
   assign map_dis = i_map_entry[ENTRY_W-1:GROUP_LSB] < i_map_disable_field;
   assign mapped_op = (i_op != OP_PREFETCH) && (i_op != OP_NONE);
   assign dma_locked = |(s_r.status & DMA_LOCK_MASK);
   assign pf_locked = |(s_r.status & PF_LOCK_MASK);
   assign reinit = i_adapter_init | i_backplane_dead;
   assign wr_status = i_reg_sel & i_reg_write & (i_reg_addr == STATUS_OFS);

   // Error events of this cycle
   always_comb begin
      ev = '0;
      ev[B_RD_TMO] = expired[T_READ] & ~i_periph_timed_out & (i_op != OP_PREFETCH); // [R1]
      ev[B_RD_SUB] = i_sub_resp & i_dma_read; // [R2]
      ev[B_CORR] = i_corr_resp & i_dma_read; // [R3]
      ev[B_CMD_ERR] = i_cmd_err_conf & mapped_op; // [R4]
      ev[B_CMD_TMO] = expired[T_CMD] & ((i_op == OP_BWRITE) || (i_op == OP_PURGE) ||
                    ((i_op == OP_BREAD) && !i_periph_timed_out)); // [R5]
      ev[B_PATH_PAR] = i_dp_check & dp_perr & ((i_op == OP_BREAD) || (i_op == OP_BWRITE) ||
                   (i_op == OP_PURGE)); // [R6]
      ev[B_BAD_MAP] = i_map_lookup & ~map_dis & ~i_map_valid & mapped_op; // [R7]
      ev[B_MAP_PAR] = i_map_lookup & ~map_dis & map_perr & mapped_op; // [R8]
      ev[B_STO] = expired[T_SEL]; // [R12]
      ev[B_SYNC] = expired[T_SYNC]; // [R13]
   end

   // Write one to clear; a same-cycle event wins unless its field was already locked
   assign clr = wr_status ? i_reg_wdata[STATUS_W-1:0] : '0; // [R14] [R24]

   // Next state: flags, locks, diagnostics, register answers
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.err = 1'b0;
      s_nxt.status = s_r.status & ~clr;
      s_nxt.status[B_CORR] = s_nxt.status[B_CORR] | ev[B_CORR];

      // Lock judged on the old state, so a clear never reopens early
      if (!dma_locked) begin
         s_nxt.status = s_nxt.status | (ev & DMA_LOCK_MASK); // [R9]
         if (|(ev & DMA_LOCK_MASK)) begin
            s_nxt.entry = i_map_entry; // [R9] [R23]
         end
      end else if (|(ev & DMA_LOCK_MASK)) begin
         s_nxt.status[B_LOST] = 1'b1; // [R11]
      end

      // Transfer field drops events silently while locked
      if (!pf_locked) begin
         s_nxt.status = s_nxt.status | (ev & PF_LOCK_MASK); // [R14]
         if (i_xfer_start && !(|(ev & PF_LOCK_MASK))) begin
            s_nxt.fail_addr = i_xfer_addr[17:2]; // [R16]
         end
      end

      // Register port answer is registered on the taking edge itself
      if (i_reg_sel) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdata = '0;
         if (i_reg_write) begin
            if (i_reg_addr == DIAG_OFS) begin
               s_nxt.diag = i_reg_wdata[31:DIAG_LSB]; // [R17] [R18]
            end else if (i_reg_addr == ENTRY_OFS) begin
               s_nxt.ack = 1'b0;
               s_nxt.err = 1'b1; // [R22]
            end
         end else begin
            unique case (i_reg_addr)
               STATUS_OFS: s_nxt.rdata = {{(32 - STATUS_W){1'b0}}, s_r.status};
               DIAG_OFS: s_nxt.rdata = {s_r.diag, i_seq_idle, 3'h0, i_config_low}; // [R21]
               ENTRY_OFS: s_nxt.rdata = {{(32 - ENTRY_W){1'b0}}, s_r.entry}; // [R23]
               default: s_nxt.rdata = '0;
            endcase
         end
      end
      // Init and dead clear status, diagnostics and entry; the failed address keeps history
      if (reinit) begin
         s_nxt.status = STATUS_RST;
         s_nxt.diag = DIAG_RST; // [R17] [R18]
         s_nxt.entry = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign o_reg_rdata = s_r.rdata;
   assign o_reg_ack = s_r.ack;
   assign o_reg_err = s_r.err;
   assign o_periph_data_en = i_mem_data_ret & ~i_sub_resp; // [R2]
   assign o_dma_err_irq = dma_locked & i_dma_error_irq_enable; // [R10]
   assign o_periph_irq = pf_locked & i_periph_xfer_irq_enable; // [R15]
   assign o_interrupt_ignore = s_r.diag[B_INTR_IGN]; // [R18]
   assign o_seq_reinit = reinit | i_dc_low; // [R21]
   assign o_failed_periph_address = s_r.fail_addr;

   // Checks
   AST_SUB_NO_DATA: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
      i_sub_resp |-> !o_periph_data_en)
      else $error("data passed on a substitute response");

   AST_SUB_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R2]
      (i_sub_resp && i_dma_read && !dma_locked && !reinit) |=> s_r.status[B_RD_SUB])
      else $error("substitute flag not set");

   AST_CORR_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R3]
      (i_corr_resp && i_dma_read && !reinit) |=> s_r.status[B_CORR])
      else $error("corrected data flag not set");

   AST_RD_TMO_PREFETCH: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R1]
      $rose(s_r.status[B_RD_TMO]) |-> $past(i_op) != OP_PREFETCH)
      else $error("read timeout set on prefetch");

   AST_CMD_ERR_PREFETCH: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R4]
      $rose(s_r.status[B_CMD_ERR]) |-> $past(i_op) != OP_PREFETCH)
      else $error("command error set on prefetch");

   AST_PATH_PAR_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R6]
      (i_dp_check && dp_perr && i_op == OP_BWRITE && !dma_locked && !reinit)
      |=> s_r.status[B_PATH_PAR])
      else $error("path parity flag not set");

   AST_LOST_ERR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R11]
      (dma_locked && |(ev & DMA_LOCK_MASK) && !reinit) |=> s_r.status[B_LOST])
      else $error("lost error not recorded");

   AST_LOST_NO_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R11]
      ((s_r.status & DMA_LOCK_MASK) == '0) |-> !o_dma_err_irq)
      else $error("interrupt without a locking flag");

   AST_LOCK_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R9]
      (dma_locked && !reinit) |=> $stable(s_r.entry) &&
      ((s_r.status & DMA_LOCK_MASK & ~$past(s_r.status)) == '0))
      else $error("locked field changed");

   AST_PF_LOCK_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R14]
      (pf_locked && !reinit) |=> ((s_r.status & PF_LOCK_MASK & ~$past(s_r.status)) == '0))
      else $error("transfer field changed while locked");

   AST_DMA_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R10]
      (!dma_locked && |(ev & DMA_LOCK_MASK) && !reinit && i_dma_error_irq_enable)
      |=> o_dma_err_irq || !i_dma_error_irq_enable)
      else $error("dma error interrupt missing");

   AST_FAIL_ADDR_FREEZE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R16]
      pf_locked |=> $stable(o_failed_periph_address))
      else $error("failed address changed while locked");

   AST_STO_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R12]
      (expired[T_SEL] && !pf_locked && !reinit) |=> s_r.status[B_STO])
      else $error("select timeout not set");

   AST_SYNC_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R13]
      (expired[T_SYNC] && !pf_locked && !reinit) |=> s_r.status[B_SYNC])
      else $error("slave sync timeout not set");

   AST_PERIPH_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R15]
      $rose(pf_locked) && i_periph_xfer_irq_enable |-> o_periph_irq)
      else $error("transfer error interrupt missing");

   AST_ENTRY_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R22]
      (i_reg_sel && i_reg_write && i_reg_addr == ENTRY_OFS) |=> o_reg_err && !o_reg_ack)
      else $error("failed entry write not refused");

   AST_ACK_OR_ERR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R22]
      !(o_reg_ack && o_reg_err))
      else $error("both acknowledge and error given");

   AST_SEQ_REINIT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R21]
      (i_dc_low || reinit) |-> o_seq_reinit)
      else $error("sequencer reinit missing");

   AST_DIAG_CLEAR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [R17]
      reinit |=> (s_r.diag == DIAG_RST) && !o_interrupt_ignore)
      else $error("diagnostic bits survive init");
endmodule : bus_adapter_error_status
`default_nettype wire

/* File: tb/periph_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Peripheral bus far end: grants mastership, answers data cycles
module periph_bus_model (
   // Clock
   input wire logic i_clk,
   // Requests from the adapter
   input wire logic i_sel_request,
   input wire logic i_data_cycle,
   // Delays in cycles, zero means silent forever
   input wire logic [15:0] i_grant_dly,
   input wire logic [15:0] i_resp_dly,
   // Answers, single-cycle pulses
   output logic o_bus_granted = 1'b0,
   output logic o_slave_resp = 1'b0
);
   int gcnt = 0;
   int rcnt = 0;
   // A silent target is how a missing device shows up
   always @(posedge i_clk) begin
      o_bus_granted <= (gcnt == 1);
      o_slave_resp <= (rcnt == 1);
      gcnt <= i_sel_request ? int'(i_grant_dly) : (gcnt > 0 ? gcnt - 1 : 0);
      rcnt <= i_data_cycle ? int'(i_resp_dly) : (rcnt > 0 ? rcnt - 1 : 0);
   end
endmodule : periph_bus_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import bae_pkg::*;
   localparam int TMO = 20;
   localparam int SYNC = 1600;
   localparam int E_RSENT = 0, E_RRET = 1, E_SUB = 2, E_CORR = 3, E_CSENT = 4, E_CDONE = 5;
   localparam int E_CERR = 6, E_DPC = 7, E_MAP = 8, E_XS = 9, E_SELQ = 10, E_DCY = 11;
   localparam int E_INIT = 12, E_DEAD = 13, E_DCL = 14;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sel, wr, dma_rd, ptmo, mv, px_en, idle, bg, sresp, ack, err, pde, dirq, pirq;
   logic iign, reinit, pde_s, rinit_s;
   logic [31:0] pv, wd, rd, dpd, q, seed;
   logic [7:0] addr;
   logic [23:0] cfg;
   logic [8:0] me;
   logic [15:0] mh, fpa, fpa_m, gd, rdl;
   logic [1:0] mhp;
   logic [3:0] dpp;
   logic [17:0] xa;
   logic [10:0] st_m;
   op_e op;
   int failures = 0;
   int cmp_count = 0;

   bus_adapter_error_status #(.READ_TMO(TMO), .CMD_TMO(TMO), .SEL_TMO(TMO)) dut (
      .i_clk(clk), .i_resetn(resetn), .i_adapter_init(pv[E_INIT]),
      .i_backplane_dead(pv[E_DEAD]), .i_dc_low(pv[E_DCL]), .i_reg_sel(sel),
      .i_reg_write(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd),
      .o_reg_ack(ack), .o_reg_err(err), .i_dma_error_irq_enable(1'b1),
      .i_periph_xfer_irq_enable(px_en), .i_map_disable_field(5'h02),
      .i_config_low(cfg), .i_op(op), .i_dma_read(dma_rd), .i_periph_timed_out(ptmo),
      .i_mem_read_sent(pv[E_RSENT]), .i_mem_data_ret(pv[E_RRET]), .i_sub_resp(pv[E_SUB]),
      .i_corr_resp(pv[E_CORR]), .i_cmd_sent(pv[E_CSENT]), .i_cmd_done(pv[E_CDONE]),
      .i_cmd_err_conf(pv[E_CERR]), .i_dp_check(pv[E_DPC]), .i_dp_data(dpd), .i_dp_par(dpp),
      .i_map_lookup(pv[E_MAP]), .i_map_entry(me), .i_map_valid(mv), .i_map_hi(mh),
      .i_map_hi_par(mhp), .i_xfer_start(pv[E_XS]), .i_xfer_addr(xa),
      .i_sel_request(pv[E_SELQ]), .i_bus_granted(bg), .i_data_cycle(pv[E_DCY]),
      .i_slave_resp(sresp), .i_seq_idle(idle), .o_periph_data_en(pde),
      .o_dma_err_irq(dirq), .o_periph_irq(pirq), .o_interrupt_ignore(iign),
      .o_seq_reinit(reinit), .o_failed_periph_address(fpa));

   periph_bus_model pm (.i_clk(clk), .i_sel_request(pv[E_SELQ]), .i_data_cycle(pv[E_DCY]),
      .i_grant_dly(gd), .i_resp_dly(rdl), .o_bus_granted(bg), .o_slave_resp(sresp));

   // Clock
   always #4 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   // One register access; answer is registered on the taking edge and read just after it
   task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      sel <= 1'b0;
      #1;
      q = rd;
      chk(32'(ack), 32'(!(w && a == ENTRY_OFS)));
      chk(32'(err), 32'(w && a == ENTRY_OFS));
   endtask : reg_acc

   // Pulse one or two event inputs for one cycle, sampling comb outputs
   task automatic fire(input int p, input int p2 = 31);
      @(posedge clk);
      pv <= (32'h1 << p) | (32'h1 << p2);
      #1;
      pde_s = pde;
      rinit_s = reinit;
      @(posedge clk);
      pv <= 32'h0;
   endtask : fire

   // Model: a locked field drops new events; DMA field marks them lost
   task automatic note(input int b);
      if (DMA_LOCK_MASK[b] && |(st_m & DMA_LOCK_MASK)) st_m[B_LOST] = 1'b1;
      else if (!(PF_LOCK_MASK[b] && |(st_m & PF_LOCK_MASK))) st_m[b] = 1'b1;
   endtask : note

   task automatic st_chk(input logic [10:0] clr);
      reg_acc(1'b0, STATUS_OFS, 32'h0);
      chk(q, {21'h0, st_m});
      chk(32'(dirq), 32'(|(st_m & DMA_LOCK_MASK)));
      chk(32'(pirq), 32'(|st_m[1:0] & px_en));
      reg_acc(1'b1, STATUS_OFS, {21'h0, clr});
      st_m = st_m & ~clr;
   endtask : st_chk

   // Hang guard, well above the three long sync waits
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial begin
      seed = lfsr(32'h88EF19AB);
      {sel, wr, dma_rd, ptmo, mv, px_en} = 6'b000001;
      {cfg, idle} = seed[24:0];
      {addr, wd, pv, dpd, dpp, me, mh, mhp, xa, gd, rdl, st_m, fpa_m} = '0;
      op = OP_NONE;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // Register map after reset
      st_chk(11'h0);
      chk(32'(fpa), 32'h0);
      reg_acc(1'b0, DIAG_OFS, 32'h0);
      chk(q, {4'h0, idle, 3'h0, cfg});
      reg_acc(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      reg_acc(1'b1, ENTRY_OFS, 32'h1FF);
      // Diagnostic bits read back, then a dead backplane clears them
      seed = lfsr(seed);
      reg_acc(1'b1, DIAG_OFS, seed);
      reg_acc(1'b0, DIAG_OFS, 32'h0);
      chk(q, {seed[31:28], idle, 3'h0, cfg});
      chk(32'(iign), 32'(seed[30]));
      fire(E_DEAD);
      chk(32'(rinit_s), 32'h1);
      reg_acc(1'b0, DIAG_OFS, 32'h0);
      chk(q, {4'h0, idle, 3'h0, cfg});
      fire(E_DCL);
      chk(32'(rinit_s), 32'h1);
      // Substitute response withholds data and locks the DMA field
      @(posedge clk);
      dma_rd <= 1'b1;
      op <= OP_DIRECT;
      me <= {1'b1, seed[7:0]};
      mhp <= 2'b11;
      fire(E_SUB, E_RRET);
      chk(32'(pde_s), 32'h0);
      note(B_RD_SUB);
      fire(E_RRET);
      chk(32'(pde_s), 32'h1);
      fire(E_MAP);
      note(B_BAD_MAP);
      st_chk(11'h200);
      st_chk(11'h004);
      // Invalid entry when unlocked; disabled group stays silent
      fire(E_MAP);
      note(B_BAD_MAP);
      reg_acc(1'b0, ENTRY_OFS, 32'h0);
      chk(q, {23'h0, me});
      st_chk(11'h010);
      @(posedge clk);
      me <= 9'h01F;
      mh <= seed[15:0];
      mhp <= {^seed[15:8], ^seed[7:0]};
      fire(E_MAP);
      st_chk(11'h0);
      // Defeated map parity fails an all-zero upper half, never on prefetch
      reg_acc(1'b1, DIAG_OFS, 32'h20000000);
      @(posedge clk);
      me <= 9'h020;
      mv <= 1'b1;
      mh <= 16'h0000;
      mhp <= 2'b11;
      fire(E_MAP);
      note(B_MAP_PAR);
      st_chk(11'h008);
      @(posedge clk);
      op <= OP_PREFETCH;
      fire(E_MAP);
      st_chk(11'h0);
      // Data path parity: forced by defeat, clean with good parity
      reg_acc(1'b1, DIAG_OFS, 32'h10000000);
      @(posedge clk);
      op <= OP_BWRITE;
      dpp <= 4'hF;
      fire(E_DPC);
      note(B_PATH_PAR);
      st_chk(11'h020);
      reg_acc(1'b1, DIAG_OFS, 32'h0);
      seed = lfsr(seed);
      @(posedge clk);
      dpd <= seed;
      dpp <= {~^seed[31:24], ~^seed[23:16], ~^seed[15:8], ~^seed[7:0]};
      fire(E_DPC);
      st_chk(11'h0);
      fire(E_CORR);
      note(B_CORR);
      st_chk(11'h100);
      // Error confirmation under every operation kind
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         op <= op_e'(k);
         fire(E_CERR);
         if (k inside {[1:4]}) note(B_CMD_ERR);
         st_chk(11'h080);
      end
      // Command timeout: buffered write, prefetch, then completed in time
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         op <= (k == 1) ? OP_PREFETCH : OP_BWRITE;
         fire(E_CSENT);
         if (k == 2) fire(E_CDONE);
         repeat (TMO + 4) @(posedge clk);
         if (k == 0) note(B_CMD_TMO);
         st_chk(11'h040);
      end
      // Read timeout: live peripheral, timed-out peripheral, prefetch
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         op <= (k == 2) ? OP_PREFETCH : OP_BREAD;
         ptmo <= (k == 1);
         fire(E_RSENT);
         repeat (TMO + 4) @(posedge clk);
         if (k == 0) note(B_RD_TMO);
         st_chk(11'h400);
      end
      // Silent peripheral bus: select timeout locks the failed address
      @(posedge clk);
      xa <= seed[17:0];
      fire(E_XS);
      fpa_m = xa[17:2];
      fire(E_SELQ);
      repeat (TMO + 4) @(posedge clk);
      note(B_STO);
      fire(E_DCY);
      repeat (SYNC + 4) @(posedge clk);
      note(B_SYNC);
      seed = lfsr(seed);
      @(posedge clk);
      xa <= seed[17:0];
      fire(E_XS);
      chk(32'(fpa), 32'(fpa_m));
      st_chk(11'h002);
      fire(E_XS);
      fpa_m = xa[17:2];
      #1;
      chk(32'(fpa), 32'(fpa_m));
      fire(E_DCY);
      repeat (SYNC + 4) @(posedge clk);
      note(B_SYNC);
      @(posedge clk);
      px_en <= 1'b0;
      st_chk(11'h001);
      // Prompt partner raises neither timeout
      @(posedge clk);
      px_en <= 1'b1;
      gd <= 16'h0003;
      rdl <= 16'h0003;
      fire(E_SELQ);
      fire(E_DCY);
      repeat (SYNC + 4) @(posedge clk);
      st_chk(11'h003);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
